/* bench/pcoic_pin_model.sv */
`timescale 1ns/10ps

// ==========================================================
// Pads and outside world of Port T and the interrupt pin
// ==========================================================
module pcoic_pin_model (
  input wire logic aclk,
  input wire logic irq_low,
  input wire logic [7:0] ext_level,
  input wire logic [7:0] port_t_out,
  input wire logic [7:0] port_t_oe,
  output logic irq_pin,
  output logic [7:0] port_t_pin_in
);
  // Pad delay of one cycle; pull-up holds the pin high when idle
  always @(posedge aclk) begin
    irq_pin <= !irq_low;
    // Driven bits read back, others show the outside level
    port_t_pin_in <= (port_t_out & port_t_oe) | (ext_level & ~port_t_oe);
  end
endmodule

/* bench/pcoic_props.sv */
`timescale 1ns/10ps

module pcoic_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [7:0] port_t_dir,
  input wire pcoic_pkg::pcoic_alt_t alt_fn,
  input wire logic bus_clock_out_pin,
  input wire logic double_clock_out_pin,
  input wire logic irq_request,
  input wire logic [7:0] port_t_out,
  input wire logic [7:0] port_t_oe
);
  // ==========================================================
  // Helper terms
  // ==========================================================
  logic [7:0] pwm_win; // PWM pins not taken by a timer
  logic [7:0] oe_exp; // Any owner wants the pin driven
  assign pwm_win = alt_fn.pwm_en & pcoic_pkg::PWM_PINS & ~alt_fn.timer_en;
  assign oe_exp = port_t_dir | alt_fn.timer_en | (alt_fn.pwm_en & pcoic_pkg::PWM_PINS)
    | (alt_fn.api_en ? pcoic_pkg::API_PINS : 8'h00);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Properties
  // ==========================================================
  // Double rate pin never holds high two cycles
  property p_dbl; double_clock_out_pin |=> !double_clock_out_pin; endproperty
  // High half period is at least two cycles
  property p_bus; $rose(bus_clock_out_pin) |=> bus_clock_out_pin; endproperty
  property p_tmr;
    |alt_fn.timer_en |=>
      ((port_t_out ^ $past(alt_fn.timer_val)) & $past(alt_fn.timer_en)) == 8'h00;
  endproperty
  property p_pwm;
    |pwm_win |=> ((port_t_out ^ $past(alt_fn.pwm_val)) & $past(pwm_win)) == 8'h00;
  endproperty
  property p_api;
    alt_fn.api_en && !alt_fn.timer_en[5] && !alt_fn.pwm_en[5]
      |=> port_t_out[5] == $past(alt_fn.api_val);
  endproperty
  property p_oe; 1'b1 |=> port_t_oe == $past(oe_exp); endproperty
  // Write channel stays closed until the response is taken
  property p_wlock; bvalid |-> !awready && !wready; endproperty
  property p_rdata; rvalid |-> rdata[31:8] == 24'h000000 && !arready; endproperty

  a_dbl: assert property (p_dbl) else $error("double rate pin high too long");
  a_bus: assert property (p_bus) else $error("clock out half period too short");
  a_tmr: assert property (p_tmr) else $error("timer value not on pin");
  a_pwm: assert property (p_pwm) else $error("pwm value not on pin");
  a_api: assert property (p_api) else $error("periodic clock not on pin 5");
  a_oe: assert property (p_oe) else $error("pin drive enable wrong");
  a_wlock: assert property (p_wlock) else $error("write ready during response");
  a_rdata: assert property (p_rdata) else $error("read data upper bits set");

  c_err: cover property (bvalid && bresp == pcoic_pkg::RESP_SLVERR);
  c_irq: cover property ($rose(irq_request));
  c_clk: cover property ($rose(bus_clock_out_pin));
endmodule

/* bench/pcoic_tb_top.sv */
`timescale 1ns/10ps

module pcoic_tb_top;
  // ==========================================================
  // Signals
  // ==========================================================
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_pin;
  logic bus_clock_out_pin, double_clock_out_pin, irq_request, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic special_mode = 1'b0, irq_ack = 1'b0, irq_low = 1'b0;
  logic [7:0] port_t_dir = 8'h00, ext_level = 8'h00;
  logic [7:0] port_t_pin_in, port_t_out, port_t_oe;
  logic [7:0] cfg [4] = '{8'h00, 8'h03, 8'h1F, 8'h21}; // Clock settings
  int half [4] = '{2, 8, 64, 64}; // Expected high phase in cycles
  pcoic_pkg::pcoic_alt_t alt_fn = '0;
  int error_cnt = 0, total_checks = 0, n;

  always #5 aclk = ~aclk;

  pcoic_top pcoic_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .special_mode, .irq_pin, .irq_ack, .port_t_dir,
    .port_t_pin_in, .alt_fn, .bus_clock_out_pin, .double_clock_out_pin, .irq_request,
    .port_t_out, .port_t_oe, .irq);
  pcoic_pin_model pcoic_pin_model_inst (.aclk, .irq_low, .ext_level, .port_t_out,
    .port_t_oe, .irq_pin, .port_t_pin_in);

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  // Ready strobes stay up between transfers: every call drives rready high again and none lowers it
  task automatic rd_reg(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    resp = rresp;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask

  // Length of one high phase of the divided clock
  task automatic half_high(output int h);
    do @(posedge aclk); while (bus_clock_out_pin !== 1'b0);
    do @(posedge aclk); while (bus_clock_out_pin !== 1'b1);
    h = 0;
    do begin
      @(posedge aclk);
      h++;
    end while (bus_clock_out_pin === 1'b1);
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(pcoic_pkg::OFF_CLK_CTL, 32'hC0);
    chk(resp, pcoic_pkg::RESP_OKAY);
    rchk(pcoic_pkg::OFF_PORT_T, 32'h00);
    // Reserved places swallow writes
    wr(pcoic_pkg::OFF_RSV_A, 8'hFF);
    rchk(pcoic_pkg::OFF_RSV_A, 32'h00);
    wr(pcoic_pkg::OFF_RSV_B, 8'hFF);
    rchk(pcoic_pkg::OFF_RSV_B, 32'h00);
    wr(12'h100, 8'h01);
    chk(resp, pcoic_pkg::RESP_SLVERR);
    // Unmapped read answers zero with an error code
    rchk(12'h100, 32'h00);
    chk(resp, pcoic_pkg::RESP_SLVERR);
    // Divider settings; second phase avoids a leftover from the old rate
    for (int i = 0; i < 4; i++) begin
      wr(pcoic_pkg::OFF_CLK_CTL, cfg[i]);
      rchk(pcoic_pkg::OFF_CLK_CTL, cfg[i]);
      repeat (2) half_high(n);
      chk(n, half[i]);
      rd = double_clock_out_pin;
      @(posedge aclk);
      chk(double_clock_out_pin, 32'(!rd[0]));
    end
    wr(pcoic_pkg::OFF_CLK_CTL, 8'hC0);
    n = 0;
    repeat (80) begin
      @(posedge aclk);
      n += bus_clock_out_pin | double_clock_out_pin;
    end
    chk(n, 0);
    // Level mode, the one normal-mode write
    wr(pcoic_pkg::OFF_INT_ENABLE, 8'h01);
    wr(pcoic_pkg::OFF_IRQ_CTL, 8'h40);
    irq_low <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({irq, irq_request}, 32'h3);
    irq_low <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(irq_request, 32'h0);
    rchk(pcoic_pkg::OFF_INT_STATUS, 32'h1);
    wr(pcoic_pkg::OFF_INT_CLEAR, 8'h03);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    wr(pcoic_pkg::OFF_IRQ_CTL, 8'hC0);
    rchk(pcoic_pkg::OFF_IRQ_CTL, 32'h40);
    rchk(pcoic_pkg::OFF_INT_STATUS, 32'h2);
    wr(pcoic_pkg::OFF_IRQ_CTL, 8'h00);
    irq_low <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(irq_request, 32'h0);
    irq_low <= 1'b0;
    // Special mode lets the edge select change again
    special_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(pcoic_pkg::OFF_IRQ_CTL, 8'hC0);
    rchk(pcoic_pkg::OFF_IRQ_CTL, 32'hC0);
    irq_low <= 1'b1;
    repeat (2) @(posedge aclk);
    irq_low <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(irq_request, 32'h1);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(irq_request, 32'h0);
    // Reset in mid-run with the strap high: bus clock out comes up enabled
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(pcoic_pkg::OFF_CLK_CTL, 32'h40);
    rchk(pcoic_pkg::OFF_IRQ_CTL, 32'h00);
    // Port T as plain outputs, then mixed, then shared with owners
    port_t_dir <= 8'hFF;
    wr(pcoic_pkg::OFF_PORT_T, 8'hA5);
    rchk(pcoic_pkg::OFF_PORT_T, 32'hA5);
    chk({port_t_oe, port_t_out}, 32'hFFA5);
    port_t_dir <= 8'h0F;
    ext_level <= 8'h3C;
    repeat (4) @(posedge aclk);
    rchk(pcoic_pkg::OFF_PORT_T, 32'h35);
    alt_fn <= '{8'hC1, 8'h81, 8'h31, 8'h10, 1'b1, 1'b1};
    repeat (2) @(posedge aclk);
    chk({port_t_oe, port_t_out & port_t_oe}, 32'hFF95);
    alt_fn <= '{8'h00, 8'h00, 8'h11, 8'h10, 1'b1, 1'b1};
    repeat (2) @(posedge aclk);
    chk({port_t_oe, port_t_out & port_t_oe}, 32'h3F34);
    end_sim;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    end_sim;
  end
endmodule

bind pcoic_top pcoic_props pcoic_props_inst (.aclk(aclk), .aresetn(aresetn),
  .awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp), .arready(arready),
  .rvalid(rvalid), .rdata(rdata), .port_t_dir(port_t_dir), .alt_fn(alt_fn),
  .bus_clock_out_pin(bus_clock_out_pin), .double_clock_out_pin(double_clock_out_pin),
  .irq_request(irq_request), .port_t_out(port_t_out), .port_t_oe(port_t_oe));

/* core/pcoic_pkg.sv */
package pcoic_pkg;

  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [11:0] OFF_CLK_CTL = 12'h01C; // Clock output control
  localparam logic [11:0] OFF_RSV_A = 12'h020; // Reserved, reads zero
  localparam logic [11:0] OFF_IRQ_CTL = 12'h024; // Interrupt pin control
  localparam logic [11:0] OFF_RSV_B = 12'h028; // Reserved, reads zero
  localparam logic [11:0] OFF_INT_STATUS = 12'h030; // Sticky event status
  localparam logic [11:0] OFF_INT_CLEAR = 12'h034; // Write one to clear
  localparam logic [11:0] OFF_INT_ENABLE = 12'h038; // Event enables
  localparam logic [11:0] OFF_PORT_T = 12'h240; // Port T data

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_IRQ_EDGE = 7; // Edge select in interrupt pin control
  localparam int BIT_IRQ_CONNECT = 6; // Pin connect in interrupt pin control
  localparam int INT_PIN_FALL = 0; // Event: falling edge seen on the pin
  localparam int INT_WRITE_LOCKED = 1; // Event: blocked edge-select write
  localparam int INT_W = 2; // Number of event bits

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] CLK_CTL_RST_NORMAL = 8'hC0;
  localparam logic [7:0] CLK_CTL_RST_SPECIAL = 8'h40;
  localparam logic [7:0] IRQ_CTL_RST = 8'h00;
  localparam logic [7:0] PORT_T_RST = 8'h00;
  localparam logic [7:0] RSV_READ = 8'h00;

  // ==========================================================
  // Port T alternative function map
  // ==========================================================
  localparam logic [7:0] PWM_PINS = 8'h31; // Pins 5, 4 and 0
  localparam logic [7:0] API_PINS = 8'h20; // Pin 5 only

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10; // aclk at 100 MHz
  localparam int BUS_PERIOD_NS = 40; // Internal bus clock period
  localparam int BUS_HALF_CYC = BUS_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int PREDIV_SHIFT = 4; // Divide by 16 stage

  // ==========================================================
  // Bus responses
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  // Clock output control layout, bit 7 down to bit 0
  typedef struct packed {
    logic bus_clock_out_disable;
    logic double_clock_out_disable;
    logic sixteen_prediv_enable;
    logic [4:0] clock_out_divider;
  } pcoic_clk_ctl_t;

  // Alternative functions competing for Port T pins
  typedef struct packed {
    logic [7:0] timer_en;
    logic [7:0] timer_val;
    logic [7:0] pwm_en;
    logic [7:0] pwm_val;
    logic api_en;
    logic api_val;
  } pcoic_alt_t;

endpackage

/* core/pcoic_top.sv */
`timescale 1ns/10ps

module pcoic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic special_mode,
  input wire logic irq_pin,
  input wire logic irq_ack,
  input wire logic [7:0] port_t_dir,
  input wire logic [7:0] port_t_pin_in,
  input wire pcoic_pkg::pcoic_alt_t alt_fn,
  output logic bus_clock_out_pin,
  output logic double_clock_out_pin,
  output logic irq_request,
  output logic [7:0] port_t_out,
  output logic [7:0] port_t_oe,
  output logic irq
);

  // ==========================================================
  // Storage
  // ==========================================================
  pcoic_pkg::pcoic_clk_ctl_t clk_ctl; // Clock output control
  logic irq_edge_select; // Falling edge mode when set
  logic irq_pin_connect; // Pin routed to the interrupt request (irq_request)
  logic irq_edge_written; // Edge select already written once
  logic [7:0] port_t_data_bits; // Port T data register
  logic [pcoic_pkg::INT_W-1:0] int_status; // Sticky events
  logic [pcoic_pkg::INT_W-1:0] int_enable; // Event enables

  // ==========================================================
  // Synchronisers for pins from outside the clock domain
  // ==========================================================
  logic mode_s1; // First stage, read only by second
  logic mode_s2; // Special mode, safe to use
  logic irq_s1; // First stage, read only by second
  logic irq_s2; // Interrupt pin level, safe to use
  logic irq_prev; // Previous pin level for edge detect
  logic [7:0] pin_s1; // First stage, read only by second
  logic [7:0] pin_s2; // Port T buffered inputs

  // Mode strap is left unreset so it settles while reset is held
  always_ff @(posedge aclk) begin
    mode_s1 <= special_mode;
    mode_s2 <= mode_s1;
  end

  // Interrupt pin and Port T pins, idle high and low respectively
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      irq_prev <= 1'b1;
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end else begin
      irq_s1 <= irq_pin;
      irq_s2 <= irq_s1;
      irq_prev <= irq_s2;
      pin_s1 <= port_t_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  logic irq_fall; // One-cycle pulse on a falling pin edge
  assign irq_fall = irq_prev & ~irq_s2;

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  logic [11:0] wr_addr; // Captured write address
  logic [31:0] wr_data; // Captured write data
  logic [3:0] wr_strb; // Captured byte enables
  logic aw_held; // Address captured, waiting for data
  logic w_held; // Data captured, waiting for address
  logic wr_fire; // Both halves present: commit now
  logic wr_lane0; // Low byte lane enabled

  assign wr_fire = aw_held & w_held & ~bvalid;
  assign wr_lane0 = wr_fire & wr_strb[0];

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      wr_addr <= 12'h000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end else if (bvalid && bready) begin
        aw_held <= 1'b0;
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (bvalid && bready) begin
        w_held <= 1'b0;
        wready <= 1'b1;
      end
    end
  end

  // Decode of the write target for the response code
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == pcoic_pkg::OFF_CLK_CTL) || (a == pcoic_pkg::OFF_RSV_A) ||
                  (a == pcoic_pkg::OFF_IRQ_CTL) || (a == pcoic_pkg::OFF_RSV_B) ||
                  (a == pcoic_pkg::OFF_INT_STATUS) || (a == pcoic_pkg::OFF_INT_CLEAR) ||
                  (a == pcoic_pkg::OFF_INT_ENABLE) || (a == pcoic_pkg::OFF_PORT_T);
  endfunction

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= pcoic_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      // Unmapped word: error, nothing stored
      bresp <= addr_mapped(wr_addr) ? pcoic_pkg::RESP_OKAY : pcoic_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Clock output control register
  // ==========================================================
  // Reset value of the disable bit depends on the mode strap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ctl <= mode_s2 ? pcoic_pkg::CLK_CTL_RST_SPECIAL : pcoic_pkg::CLK_CTL_RST_NORMAL;
    end else if (wr_lane0 && wr_addr == pcoic_pkg::OFF_CLK_CTL) begin
      clk_ctl <= wr_data[7:0];
    end
  end

  // ==========================================================
  // Interrupt pin control register
  // ==========================================================
  logic irq_ctl_wr; // Write to interrupt pin control this cycle
  logic edge_wr_ok; // Edge select may be changed now
  assign irq_ctl_wr = wr_lane0 && (wr_addr == pcoic_pkg::OFF_IRQ_CTL);
  assign edge_wr_ok = mode_s2 | ~irq_edge_written;

  // Connect bit is free; edge select locks after one normal-mode write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_edge_select <= pcoic_pkg::IRQ_CTL_RST[pcoic_pkg::BIT_IRQ_EDGE];
      irq_pin_connect <= pcoic_pkg::IRQ_CTL_RST[pcoic_pkg::BIT_IRQ_CONNECT];
      irq_edge_written <= 1'b0;
    end else if (irq_ctl_wr) begin
      irq_pin_connect <= wr_data[pcoic_pkg::BIT_IRQ_CONNECT];
      if (edge_wr_ok) begin
        irq_edge_select <= wr_data[pcoic_pkg::BIT_IRQ_EDGE];
        // Only normal mode consumes the single write
        irq_edge_written <= irq_edge_written | ~mode_s2;
      end
    end
  end

  // ==========================================================
  // Port T data register
  // ==========================================================
  // Writes always land in storage, whatever function owns the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_t_data_bits <= pcoic_pkg::PORT_T_RST;
    end else if (wr_lane0 && wr_addr == pcoic_pkg::OFF_PORT_T) begin
      port_t_data_bits <= wr_data[7:0];
    end
  end

  // ==========================================================
  // Clock outputs
  // ==========================================================
  logic [10:0] half_cnt; // aclk cycles in the current half period
  logic [10:0] half_len; // Half period of the divided clock

  // Half period = bus half period * (divider + 1), times 16 if set
  always_comb begin
    half_len = 11'(({6'h00, clk_ctl.clock_out_divider} + 11'h001) *
                   11'(pcoic_pkg::BUS_HALF_CYC));
    if (clk_ctl.sixteen_prediv_enable) begin
      half_len = 11'(half_len << pcoic_pkg::PREDIV_SHIFT);
    end
  end

  // Divided bus-rate clock; >= keeps a shortened divider from wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt <= 11'h000;
      bus_clock_out_pin <= 1'b0;
    end else if (clk_ctl.bus_clock_out_disable) begin
      half_cnt <= 11'h000;
      bus_clock_out_pin <= 1'b0;
    end else if (half_cnt >= half_len - 11'h001) begin
      half_cnt <= 11'h000;
      bus_clock_out_pin <= ~bus_clock_out_pin;
    end else begin
      half_cnt <= half_cnt + 11'h001;
    end
  end

  // Double rate: toggles every aclk, twice the bus rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      double_clock_out_pin <= 1'b0;
    end else if (clk_ctl.double_clock_out_disable) begin
      double_clock_out_pin <= 1'b0;
    end else begin
      double_clock_out_pin <= ~double_clock_out_pin;
    end
  end

  // ==========================================================
  // External interrupt request
  // ==========================================================
  logic edge_latch; // Falling edge held until serviced

  // Set wins over acknowledge so a fresh edge is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_latch <= 1'b0;
    end else if (irq_edge_select && irq_fall) begin
      edge_latch <= 1'b1;
    end else if (irq_ack) begin
      edge_latch <= 1'b0;
    end
  end

  // Request follows level or latch, only while connected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
    end else if (!irq_pin_connect) begin
      irq_request <= 1'b0;
    end else if (irq_edge_select) begin
      irq_request <= edge_latch;
    end else begin
      irq_request <= ~irq_s2;
    end
  end

  // ==========================================================
  // Port T pin ownership
  // ==========================================================
  logic [7:0] next_out; // Pin value chosen by priority
  logic [7:0] next_oe; // Pin driven by some owner

  // Timer first, then PWM on its pins, then periodic clock, then GPIO
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (alt_fn.timer_en[i]) begin
        next_out[i] = alt_fn.timer_val[i];
        next_oe[i] = 1'b1;
      end else if (pcoic_pkg::PWM_PINS[i] && alt_fn.pwm_en[i]) begin
        next_out[i] = alt_fn.pwm_val[i];
        next_oe[i] = 1'b1;
      end else if (pcoic_pkg::API_PINS[i] && alt_fn.api_en) begin
        next_out[i] = alt_fn.api_val;
        next_oe[i] = 1'b1;
      end else begin
        next_out[i] = port_t_data_bits[i];
        next_oe[i] = port_t_dir[i];
      end
    end
  end

  // Registered so pin outputs never glitch on owner changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_t_out <= 8'h00;
      port_t_oe <= 8'h00;
    end else begin
      port_t_out <= next_out;
      port_t_oe <= next_oe;
    end
  end

  // ==========================================================
  // Event status, enable and interrupt line
  // ==========================================================
  logic [pcoic_pkg::INT_W-1:0] int_set; // Events this cycle
  logic [pcoic_pkg::INT_W-1:0] int_clr; // Software clears this cycle

  assign int_set[pcoic_pkg::INT_PIN_FALL] = irq_fall;
  assign int_set[pcoic_pkg::INT_WRITE_LOCKED] = irq_ctl_wr & ~edge_wr_ok;
  assign int_clr = (wr_lane0 && wr_addr == pcoic_pkg::OFF_INT_CLEAR) ?
                   wr_data[pcoic_pkg::INT_W-1:0] : '0;

  // Sticky bits: a set in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
    end
  end

  // Enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_enable <= '0;
    end else if (wr_lane0 && wr_addr == pcoic_pkg::OFF_INT_ENABLE) begin
      int_enable <= wr_data[pcoic_pkg::INT_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [7:0] rd_byte; // Selected register value
  logic [1:0] rd_resp; // Response for the selected address

  // Read mux; reserved and clear registers answer zero
  always_comb begin
    rd_resp = pcoic_pkg::RESP_OKAY;
    rd_byte = 8'h00;
    unique case (araddr)
      pcoic_pkg::OFF_CLK_CTL: rd_byte = clk_ctl;
      pcoic_pkg::OFF_RSV_A: rd_byte = pcoic_pkg::RSV_READ;
      pcoic_pkg::OFF_RSV_B: rd_byte = pcoic_pkg::RSV_READ;
      pcoic_pkg::OFF_IRQ_CTL: begin
        rd_byte[pcoic_pkg::BIT_IRQ_EDGE] = irq_edge_select;
        rd_byte[pcoic_pkg::BIT_IRQ_CONNECT] = irq_pin_connect;
      end
      pcoic_pkg::OFF_INT_STATUS: rd_byte = 8'(int_status);
      pcoic_pkg::OFF_INT_CLEAR: rd_byte = 8'h00;
      pcoic_pkg::OFF_INT_ENABLE: rd_byte = 8'(int_enable);
      pcoic_pkg::OFF_PORT_T: begin
        // Output pins read storage, input pins read the pin
        rd_byte = (port_t_dir & port_t_data_bits) | (~port_t_dir & pin_s2);
      end
      default: rd_resp = pcoic_pkg::RESP_SLVERR;
    endcase
  end

  // Answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= pcoic_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_resp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule
